// [core/mhp_master_port.sv]
// master maintenance port: command capture, call/error monitor, sequencer
// assumes transfer flag and command word are asynchronous, the rest
// synchronous to clk_sys; outside controller pulses the clear strobes
//
// How it works
// - command word: unit id, op code, address
// - command active only while transfer flag set
// - accept only when selector byte equals 41 hex
// - copy function byte, clear transfer flag
// - sequencer forwards low bits or generates code
// - four-bit op-code register feeds unit cores
// - error switch loads sequencer's own op code
// - monitor decides switch, else three-bit reason
// - switch on system or error condition, permitted
// - set response bits, start sequencer or reason
// - control byte holds eight controller flags
// - step-primed flag handled by outside controller
// - system-reset flag starts processor reset
// - terminate request abandons command or switch
// - allow flags gate automatic switches and calls
// - drive response bits and condition byte
// - set system error and attention bits
// - set message-complete and switch-complete on finish
// - busy-blocked reason codes 001, 010, 110
// - permission-blocked reason codes 100, 101, 110, 111
// - set command-complete or command-failed
// - condition bit mirrors run flag
`timescale 1ns/100ps
module mhp_master_port (
    input wire logic clk_sys, // 10 MHz system clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic transfer_flag, // asynchronous command transfer flag
    input wire logic [15:0] shared_command_word, // asynchronous command
    input wire logic [7:0] processor_control_byte, // controller flags
    input wire logic [4:0] resp_clear, // response clear strobes
    input wire logic [5:0] cond_clear, // condition clear strobes
    input wire mhp_pkg::mhp_unit_ev_t unit_ev, // unit event pulses
    input wire logic unit_done, // unit cores finished the operation
    input wire logic unit_abort, // unit cores ended abnormally
    input wire logic run_flag, // processor internal run flag
    output logic transfer_clear, // clears transfer flag outside
    output logic [3:0] unit_opcode, // op code to unit cores
    output logic unit_go, // one-cycle start to unit cores
    output logic unit_cancel, // one-cycle abandon to unit cores
    output logic [7:0] processor_response_byte, // response byte
    output logic [7:0] condition_byte // condition byte
);
    // ---------------------------------------------------------------
    // command capture
    // ---------------------------------------------------------------
    logic flag_s1, flag_s2, flag_s3;
    logic [15:0] cmd_s1, cmd_s2;
    logic [7:0] cmd_hold;
    mhp_pkg::mhp_state_t state;
    mhp_pkg::mhp_kind_t kind;
    logic pend_mcw, pend_mcp, pend_err, sr_d;
    logic accept, dec_start, dec_block, busy_bits;
    logic [2:0] dec_reason;
    mhp_pkg::mhp_kind_t dec_kind;
    logic ctl_sr, ctl_tr, ctl_ac, ctl_as;
    logic err_now, sys_now;

    // step and availability flags are kept by the controller; only these four act here
    assign ctl_sr = processor_control_byte[mhp_pkg::C_SR];
    assign ctl_tr = processor_control_byte[mhp_pkg::C_TR];
    assign ctl_ac = processor_control_byte[mhp_pkg::C_AC];
    assign ctl_as = processor_control_byte[mhp_pkg::C_AS];
    assign err_now = unit_ev.pv | unit_ev.il | unit_ev.ae;
    assign sys_now = unit_ev.term_err | unit_ev.parity;
    assign busy_bits = processor_response_byte[mhp_pkg::R_MC]
                     | processor_response_byte[mhp_pkg::R_SC];

    // two-stage synchronisers; flag gets one extra stage so the word settles
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            flag_s1 <= 1'b0;
            flag_s2 <= 1'b0;
            flag_s3 <= 1'b0;
            cmd_s1 <= 16'h0000;
            cmd_s2 <= 16'h0000;
        end else begin
            flag_s1 <= transfer_flag;
            flag_s2 <= flag_s1;
            flag_s3 <= flag_s2;
            cmd_s1 <= shared_command_word;
            cmd_s2 <= cmd_s1;
        end
    end

    // accept an active command addressed to this processor when idle
    assign accept = flag_s3 && !transfer_clear
                 && cmd_s2[mhp_pkg::SEL_HI:mhp_pkg::SEL_LO] == mhp_pkg::CP_SELECT
                 && state == mhp_pkg::ST_IDLE && !ctl_sr && !ctl_tr && !dec_start
                 && !dec_block;

    // holding register and transfer-flag clear, held until flag drops
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cmd_hold <= 8'h00;
            transfer_clear <= 1'b0;
        end else if (accept) begin
            cmd_hold <= cmd_s2[mhp_pkg::FN_HI:0];
            transfer_clear <= 1'b1;
        end else if (!flag_s3) begin
            transfer_clear <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // call and error monitor
    // ---------------------------------------------------------------
    // pending events; a new event wins over its own consumption
    always_ff @(posedge clk_sys) begin
        if (!rst_n || ctl_sr || ctl_tr) begin
            pend_mcw <= 1'b0;
            pend_mcp <= 1'b0;
            pend_err <= 1'b0;
        end else begin
            pend_err <= sys_now || err_now
                     || (pend_err && !(state == mhp_pkg::ST_IDLE));
            pend_mcw <= unit_ev.monitor_call_wait
                     || (pend_mcw && !(state == mhp_pkg::ST_IDLE && !pend_err));
            pend_mcp <= unit_ev.monitor_call_proceed
                     || (pend_mcp && !(state == mhp_pkg::ST_IDLE && !pend_err && !pend_mcw));
        end
    end

    // decide: error first, then wait call, then proceed call
    always_comb begin
        dec_start = 1'b0;
        dec_block = 1'b0;
        dec_reason = mhp_pkg::RZ_NOOP;
        dec_kind = mhp_pkg::KD_MCP;
        if (state == mhp_pkg::ST_IDLE && !ctl_sr && !ctl_tr) begin
            if (pend_err) begin
                dec_kind = mhp_pkg::KD_ERR;
                if (!ctl_as) begin
                    dec_block = 1'b1;
                    dec_reason = mhp_pkg::RZ_ERR_AS;
                end else if (busy_bits) begin
                    dec_block = 1'b1;
                    dec_reason = mhp_pkg::RZ_ERR_BUSY;
                end else begin
                    dec_start = 1'b1;
                end
            end else if (pend_mcw) begin
                dec_kind = mhp_pkg::KD_MCW;
                if (!ctl_ac) begin
                    dec_block = 1'b1;
                    dec_reason = mhp_pkg::RZ_MCW_AC;
                end else if (!ctl_as) begin
                    dec_block = 1'b1;
                    dec_reason = mhp_pkg::RZ_MCW_AS;
                end else if (busy_bits) begin
                    dec_block = 1'b1;
                    dec_reason = mhp_pkg::RZ_MCW_BUSY;
                end else begin
                    dec_start = 1'b1;
                end
            end else if (pend_mcp) begin
                if (!ctl_ac) begin
                    dec_block = 1'b1;
                    dec_reason = mhp_pkg::RZ_MCP_AC;
                end else if (busy_bits) begin
                    dec_block = 1'b1;
                    dec_reason = mhp_pkg::RZ_MCP_BUSY;
                end else begin
                    dec_start = 1'b1;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    // state, op-code register and unit strobes
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= mhp_pkg::ST_IDLE;
            kind <= mhp_pkg::KD_MCP;
            unit_opcode <= 4'h0;
            unit_go <= 1'b0;
            unit_cancel <= 1'b0;
            sr_d <= 1'b0;
        end else begin
            sr_d <= ctl_sr;
            unit_go <= 1'b0;
            unit_cancel <= 1'b0;
            if (ctl_sr) begin
                state <= mhp_pkg::ST_IDLE;
                if (!sr_d) begin
                    unit_opcode <= mhp_pkg::OP_RST;
                    unit_go <= 1'b1;
                end
            end else if (ctl_tr) begin
                state <= mhp_pkg::ST_IDLE;
                unit_cancel <= (state != mhp_pkg::ST_IDLE);
            end else begin
                unique case (state)
                    mhp_pkg::ST_IDLE: begin
                        if (dec_start) begin
                            state <= mhp_pkg::ST_AUTO;
                            kind <= dec_kind;
                            unit_go <= 1'b1;
                            unique case (dec_kind)
                                mhp_pkg::KD_ERR: unit_opcode <= mhp_pkg::OP_ERR;
                                mhp_pkg::KD_MCW: unit_opcode <= mhp_pkg::OP_MCW;
                                mhp_pkg::KD_MCP: unit_opcode <= mhp_pkg::OP_MCP;
                            endcase
                        end else if (accept) begin
                            state <= mhp_pkg::ST_CMD;
                            unit_opcode <= cmd_s2[3:0];
                            unit_go <= 1'b1;
                        end
                    end
                    mhp_pkg::ST_CMD, mhp_pkg::ST_AUTO: begin
                        if (unit_done || unit_abort) begin
                            state <= mhp_pkg::ST_IDLE;
                        end
                    end
                    default: state <= mhp_pkg::ST_IDLE;
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // response and condition bytes
    // ---------------------------------------------------------------
    logic fin_auto, fin_cmd, tr_abandon;
    assign fin_auto = state == mhp_pkg::ST_AUTO && !ctl_sr && !ctl_tr;
    assign fin_cmd = state == mhp_pkg::ST_CMD && !ctl_sr && !ctl_tr;
    assign tr_abandon = ctl_tr && !ctl_sr;

    // response byte: hardware set wins over controller clear
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            processor_response_byte <= mhp_pkg::BYTE_RESET;
        end else begin
            processor_response_byte[mhp_pkg::R_SE] <= (unit_ev.parity && !ctl_sr)
                || (processor_response_byte[mhp_pkg::R_SE] && !resp_clear[mhp_pkg::R_SE]);
            processor_response_byte[mhp_pkg::R_AT] <= (fin_auto && unit_abort)
                || (tr_abandon && state == mhp_pkg::ST_AUTO)
                || (processor_response_byte[mhp_pkg::R_AT] && !resp_clear[mhp_pkg::R_AT]);
            processor_response_byte[mhp_pkg::R_MC] <=
                (fin_auto && unit_done && kind != mhp_pkg::KD_ERR)
                || (processor_response_byte[mhp_pkg::R_MC] && !resp_clear[mhp_pkg::R_MC]);
            processor_response_byte[mhp_pkg::R_SC] <=
                (fin_auto && unit_done && kind != mhp_pkg::KD_MCP)
                || (processor_response_byte[mhp_pkg::R_SC] && !resp_clear[mhp_pkg::R_SC]);
            if (dec_block) begin
                processor_response_byte[mhp_pkg::R_RZ_HI:mhp_pkg::R_RZ_LO] <= dec_reason;
            end else if (resp_clear[mhp_pkg::R_RZ]) begin
                processor_response_byte[mhp_pkg::R_RZ_HI:mhp_pkg::R_RZ_LO] <= mhp_pkg::RZ_NOOP;
            end
            processor_response_byte[7] <= 1'b0;
        end
    end

    // condition byte: flags sticky until cleared, run flag mirrored
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            condition_byte <= mhp_pkg::BYTE_RESET;
        end else begin
            condition_byte[mhp_pkg::K_CC] <= (fin_cmd && unit_done)
                || (condition_byte[mhp_pkg::K_CC] && !cond_clear[mhp_pkg::K_CC]);
            condition_byte[mhp_pkg::K_AB] <= (fin_cmd && unit_abort)
                || (tr_abandon && state == mhp_pkg::ST_CMD)
                || (condition_byte[mhp_pkg::K_AB] && !cond_clear[mhp_pkg::K_AB]);
            condition_byte[mhp_pkg::K_PE] <= unit_ev.parity
                || (condition_byte[mhp_pkg::K_PE] && !cond_clear[mhp_pkg::K_PE]);
            condition_byte[mhp_pkg::K_IL] <= unit_ev.il
                || (condition_byte[mhp_pkg::K_IL] && !cond_clear[mhp_pkg::K_IL]);
            condition_byte[mhp_pkg::K_AE] <= unit_ev.ae
                || (condition_byte[mhp_pkg::K_AE] && !cond_clear[mhp_pkg::K_AE]);
            condition_byte[mhp_pkg::K_PV] <= unit_ev.pv
                || (condition_byte[mhp_pkg::K_PV] && !cond_clear[mhp_pkg::K_PV]);
            condition_byte[mhp_pkg::K_RB] <= run_flag;
            condition_byte[7] <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    AST_ACCEPT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept |=> transfer_clear && cmd_hold == $past(cmd_s2[7:0]))
        else $error("accepted command not held or flag not cleared");
    AST_SELECT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(transfer_clear) |-> $past(cmd_s2[15:8]) == mhp_pkg::CP_SELECT)
        else $error("command taken with wrong selector byte");
    AST_FORWARD: assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept |=> unit_go && unit_opcode == $past(cmd_s2[3:0]) && state == mhp_pkg::ST_CMD)
        else $error("function bits not forwarded to op-code register");
    AST_ERRCODE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        dec_start && dec_kind == mhp_pkg::KD_ERR |=> unit_go && unit_opcode == mhp_pkg::OP_ERR)
        else $error("error switch did not load generated op code");
    AST_GATE_SW: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !ctl_as |-> !(dec_start && dec_kind != mhp_pkg::KD_MCP))
        else $error("switch started while allow-switch clear");
    AST_GATE_CALL: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !ctl_ac && state == mhp_pkg::ST_IDLE |=> state != mhp_pkg::ST_AUTO || kind == mhp_pkg::KD_ERR)
        else $error("call started while allow-call clear");
    AST_REASON: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state == mhp_pkg::ST_IDLE && pend_mcp && !pend_mcw && !pend_err && !ctl_ac
        && !ctl_sr && !ctl_tr |=> processor_response_byte[6:4] == mhp_pkg::RZ_MCP_AC)
        else $error("blocked call did not post reason 101");
    AST_TERM: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ctl_tr |=> state == mhp_pkg::ST_IDLE && !unit_go)
        else $error("terminate request did not abandon work");
    AST_MSG: assert property (@(posedge clk_sys) disable iff (!rst_n)
        fin_auto && unit_done && kind == mhp_pkg::KD_MCP |=> processor_response_byte[2]
        && state == mhp_pkg::ST_IDLE)
        else $error("message-complete not set after call");
    AST_RUN: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ##1 condition_byte[mhp_pkg::K_RB] == $past(run_flag))
        else $error("run mirror does not follow run flag");
    AST_SE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        unit_ev.parity && !ctl_sr |=> processor_response_byte[0] ##1 1'b1)
        else $error("parity fault did not set system error bit");

endmodule : mhp_master_port

// [core/mhp_pkg.sv]
// constants and types for the master maintenance port
// assumes the communication file fields arrive as plain ports
package mhp_pkg;
    // ---------------------------------------------------------------
    // command word layout
    // ---------------------------------------------------------------
    localparam int SEL_HI = 15; // selector byte, printed bits 0-7
    localparam int SEL_LO = 8;
    localparam int FN_HI = 7; // function byte, eight low bits
    localparam logic [7:0] CP_SELECT = 8'h41;
    // ---------------------------------------------------------------
    // control byte flag positions
    // ---------------------------------------------------------------
    localparam int C_CA = 0; // processor_available
    localparam int C_CT = 1; // test_handover
    localparam int C_SA = 2; // step_active
    localparam int C_SP = 3; // step_primed
    localparam int C_SR = 4; // system_reset
    localparam int C_TR = 5; // terminate_request
    localparam int C_AC = 6; // allow_call
    localparam int C_AS = 7; // allow_switch
    // ---------------------------------------------------------------
    // response byte layout
    // ---------------------------------------------------------------
    localparam int R_SE = 0; // system_error_flag
    localparam int R_AT = 1; // irregular_end_flag
    localparam int R_MC = 2; // message_complete
    localparam int R_SC = 3; // switch_complete
    localparam int R_RZ_LO = 4; // reason_code, bits 6:4
    localparam int R_RZ_HI = 6;
    localparam int R_RZ = 4; // clear-strobe index of reason_code
    // ---------------------------------------------------------------
    // condition byte layout
    // ---------------------------------------------------------------
    localparam int K_CC = 0; // command_complete
    localparam int K_AB = 1; // command_failed
    localparam int K_PE = 2; // parity_fault
    localparam int K_IL = 3; // bad_opcode
    localparam int K_AE = 4; // arithmetic_exception
    localparam int K_PV = 5; // protect_violation
    localparam int K_RB = 6; // run_flag_mirror
    localparam logic [7:0] BYTE_RESET = 8'h00;
    // ---------------------------------------------------------------
    // reason codes and generated op codes
    // ---------------------------------------------------------------
    localparam logic [2:0] RZ_NOOP = 3'h0;
    localparam logic [2:0] RZ_MCP_BUSY = 3'h1;
    localparam logic [2:0] RZ_MCW_BUSY = 3'h2;
    localparam logic [2:0] RZ_ERR_BUSY = 3'h6;
    localparam logic [2:0] RZ_MCW_AC = 3'h4;
    localparam logic [2:0] RZ_MCP_AC = 3'h5;
    localparam logic [2:0] RZ_MCW_AS = 3'h6;
    localparam logic [2:0] RZ_ERR_AS = 3'h7;
    localparam logic [3:0] OP_MCW = 4'hA;
    localparam logic [3:0] OP_MCP = 4'hB;
    localparam logic [3:0] OP_ERR = 4'hC;
    localparam logic [3:0] OP_RST = 4'hD;
    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef struct packed {
        logic monitor_call_wait; // monitor_call_wait decoded
        logic monitor_call_proceed; // monitor_call_proceed decoded
        logic term_err; // terminate error
        logic parity; // parity_fault
        logic pv; // protect_violation
        logic il; // bad_opcode
        logic ae; // arithmetic_exception
    } mhp_unit_ev_t;
    typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_AUTO} mhp_state_t;
    typedef enum logic [1:0] {KD_MCP, KD_MCW, KD_ERR} mhp_kind_t;
endpackage : mhp_pkg

// [verif/mhp_pp_model.sv]
// peripheral processor side and unit cores facing the master port
// assumes clk_sys and rst_n are shared with the port under test
`timescale 1ns/100ps
module mhp_pp_model (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic post, // bench wants a command posted
    input wire logic fail, // end the next unit operation abnormally
    input wire logic transfer_clear, // port clears the transfer flag
    input wire logic unit_go, // start to the unit cores
    input wire logic unit_cancel, // abandon to the unit cores
    output logic transfer_flag, // transfer flag in the communication file
    output logic unit_done, // unit cores finished
    output logic unit_abort // unit cores ended abnormally
);
    // ---------------------------------------------------------------
    // transfer flag
    // ---------------------------------------------------------------
    logic post_q;
    logic [2:0] busy_cnt;
    // raise on a new post, drop when cleared or withdrawn
    always_ff @(posedge clk_sys) begin
        post_q <= post;
        if (!rst_n || !post || transfer_clear) begin
            transfer_flag <= 1'b0;
        end else if (!post_q) begin
            transfer_flag <= 1'b1;
        end
    end
    // ---------------------------------------------------------------
    // unit cores
    // ---------------------------------------------------------------
    // answer each start six cycles later, nothing after an abandon
    always_ff @(posedge clk_sys) begin
        unit_done <= 1'b0;
        unit_abort <= 1'b0;
        if (!rst_n || unit_cancel) begin
            busy_cnt <= 3'h0;
        end else if (unit_go) begin
            busy_cnt <= 3'h6;
        end else if (busy_cnt != 3'h0) begin
            busy_cnt <= busy_cnt - 3'h1;
            unit_done <= (busy_cnt == 3'h1) && !fail;
            unit_abort <= (busy_cnt == 3'h1) && fail;
        end
    end
endmodule : mhp_pp_model

// [verif/master_maintenance_port_test.sv]
// self-checking bench for the master maintenance port
// assumes the partner model in mhp_pp_model.sv
`timescale 1ns/100ps
module master_maintenance_port_test;
    // ---------------------------------------------------------------
    // signals and instances
    // ---------------------------------------------------------------
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] word = 16'h0000;
    logic [7:0] ctrl = 8'h00;
    logic [4:0] rclr = 5'h00;
    logic [5:0] cclr = 6'h00;
    mhp_pkg::mhp_unit_ev_t ev = '0;
    logic post = 1'b0;
    logic fail = 1'b0;
    logic run = 1'b0;
    logic flag, done, abrt, tclr, go, cancel;
    logic [3:0] op;
    logic [7:0] resp, cond;
    int err_total = 0;
    int comparisons = 0;
    int cyc = 0;
    int go_cnt = 0;
    int cancel_cnt = 0;
    logic [6:0] a_ev [7] = '{7'h20, 7'h40, 7'h04, 7'h02, 7'h01, 7'h08, 7'h10};
    logic [3:0] a_op [7] = '{4'hB, 4'hA, 4'hC, 4'hC, 4'hC, 4'hC, 4'hC};
    logic [7:0] a_rsp [7] = '{8'h04, 8'h0C, 8'h08, 8'h08, 8'h08, 8'h09, 8'h08};
    logic [7:0] a_cnd [7] = '{8'h00, 8'h00, 8'h20, 8'h08, 8'h10, 8'h04, 8'h00};
    logic [7:0] b_ctl [7] = '{8'h80, 8'h80, 8'h40, 8'h40, 8'hC0, 8'hC0, 8'hC0};
    logic [6:0] b_ev [7] = '{7'h40, 7'h20, 7'h04, 7'h40, 7'h20, 7'h40, 7'h04};
    logic [2:0] b_rz [7] = '{3'h4, 3'h5, 3'h7, 3'h6, 3'h1, 3'h2, 3'h6};
    mhp_master_port i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .transfer_flag(flag),
        .shared_command_word(word), .processor_control_byte(ctrl), .resp_clear(rclr),
        .cond_clear(cclr), .unit_ev(ev), .unit_done(done), .unit_abort(abrt),
        .run_flag(run), .transfer_clear(tclr), .unit_opcode(op), .unit_go(go),
        .unit_cancel(cancel), .processor_response_byte(resp), .condition_byte(cond));
    mhp_pp_model i_pp (.clk_sys(clk_sys), .rst_n(rst_n), .post(post), .fail(fail),
        .transfer_clear(tclr), .unit_go(go), .unit_cancel(cancel),
        .transfer_flag(flag), .unit_done(done), .unit_abort(abrt));
    // clock, start and abandon counters, hang limit
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (go === 1'b1) go_cnt <= go_cnt + 1;
        if (cancel === 1'b1) cancel_cnt <= cancel_cnt + 1;
        if (cyc == 2000) begin
            err_total = err_total + 1;
            end_of_test();
        end
    end
    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : tick
    // pulse every clear strobe for one cycle
    task automatic clear_all();
        rclr = 5'h1F;
        cclr = 6'h3F;
        tick(1);
        rclr = 5'h00;
        cclr = 6'h00;
        tick(1);
    endtask : clear_all
    task automatic pulse(input logic [6:0] e);
        ev = mhp_pkg::mhp_unit_ev_t'(e);
        tick(1);
        ev = '0;
    endtask : pulse
    // flag dropped and seen low before the word changes, word settles before raise
    task automatic command(input logic [15:0] w);
        post = 1'b0;
        tick(4);
        word = w;
        tick(3);
        post = 1'b1;
    endtask : command
    task automatic expect_go(input logic [3:0] exp_op);
        for (int n = 0; n < 20 && go !== 1'b1; n++) begin
            tick(1);
        end
        check("start and op code", {4'h8, exp_op}, {go, 3'h0, op});
    endtask : expect_go
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test
    // ---------------------------------------------------------------
    // sequence
    // ---------------------------------------------------------------
    initial begin
        int base;
        tick(8);
        rst_n = 1'b1;
        tick(1);
        check("response reset", 8'h00, resp);
        check("condition reset", 8'h00, cond);
        command(16'h4235);
        tick(20);
        check("foreign flag", 8'h01, {7'h0, flag});
        check("foreign starts", 8'h00, 8'(go_cnt));
        command(16'h4137);
        expect_go(4'h7);
        tick(8);
        check("flag cleared", 8'h00, {7'h0, flag});
        check("command complete", 8'h01, cond);
        post = 1'b0;
        clear_all();
        fail = 1'b1;
        tick(4);
        command(16'h41AC);
        expect_go(4'hC);
        tick(8);
        check("command failed", 8'h02, cond);
        post = 1'b0;
        fail = 1'b0;
        run = 1'b1;
        tick(2);
        check("run mirror", 8'h01, {7'h0, cond[6]});
        run = 1'b0;
        ctrl = 8'hC0;
        foreach (a_ev[i]) begin
            clear_all();
            pulse(a_ev[i]);
            expect_go(a_op[i]);
            tick(10);
            check("auto response", a_rsp[i], resp);
            check("auto condition", a_cnd[i], cond);
        end
        foreach (b_ev[i]) begin
            clear_all();
            ctrl = b_ctl[i];
            if (i > 3) begin
                pulse(7'h20);
                tick(12);
            end
            base = go_cnt;
            pulse(b_ev[i]);
            tick(6);
            check("reason", {5'h0, b_rz[i]}, {5'h0, resp[6:4]});
            check("blocked starts", 8'h00, 8'(go_cnt - base));
        end
        clear_all();
        pulse(7'h40);
        expect_go(4'hA);
        ctrl = 8'hE0;
        tick(4);
        check("cancels", 8'h01, 8'(cancel_cnt));
        check("auto abandoned", 8'h02, resp);
        ctrl = 8'h00;
        tick(2);
        ctrl = 8'h10;
        expect_go(4'hD);
        ctrl = 8'h00;
        tick(10);
        end_of_test();
    end
endmodule : master_maintenance_port_test
